/* File: hdl/rag_pkg.sv */
package rag_pkg;

  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ADC_FS_HZ = 274_000;
  localparam logic [7:0] ADC_DIV = 8'((SYS_CLK_HZ + ADC_FS_HZ / 2) / ADC_FS_HZ);
  localparam int STARTUP_NS = 100_000;
  localparam logic [11:0] STARTUP_CYC = 12'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [2:0] SEL_RSSI = 3'h0;
  localparam logic [2:0] SEL_TEMP = 3'h1;
  localparam logic [2:0] SEL_SUPPLY = 3'h2;

  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h01;
  localparam logic [7:0] ADDR_RES_LOW = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_ATTACK = 8'h04;
  localparam logic [7:0] ADDR_DECAY = 8'h05;
  localparam logic [7:0] ADDR_TH_LOW = 8'h06;
  localparam logic [7:0] ADDR_TH_HIGH = 8'h07;
  localparam logic [7:0] ADDR_TH_HYS = 8'h08;
  localparam logic [7:0] ADDR_TH_OFFS = 8'h09;
  localparam logic [7:0] ADDR_DGC = 8'h0a;
  localparam logic [7:0] ADDR_START = 8'h0b;
  localparam logic [7:0] ADDR_FREEZE = 8'h0c;
  localparam logic [7:0] ADDR_LEVEL = 8'h0d;

  localparam int STATUS_EOC_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;

  localparam logic [3:0] ATTACK_RST = 4'h4;
  localparam logic [3:0] DECAY_RST = 4'h4;
  localparam logic [7:0] TH_LOW_RST = 8'h08;
  localparam logic [7:0] TH_HIGH_RST = 8'h04;
  localparam logic [7:0] TH_HYS_RST = 8'h15;
  localparam logic [7:0] TH_OFFS_RST = 8'h40;
  localparam logic [7:0] DGC_RST = 8'h0f;
  localparam logic [2:0] COND_RST = 3'h0;

  typedef enum logic [1:0] {GS_MAX, GS_MID, GS_MIN} rag_gain_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rag_cmd_t;

  typedef struct packed {
    logic [2:0] sel;
    logic [3:0] att;
    logic [3:0] dec;
    logic [7:0] th_lo;
    logic [7:0] th_hi;
    logic [7:0] hys;
    logic [7:0] offs;
    logic [7:0] digital_gain_correction;
    logic [2:0] start_cfg;
    logic [2:0] frz_cfg;
    logic [9:0] res;
    logic eoc;
    logic ref_en;
    logic su_busy;
    logic [11:0] su_cnt;
    logic [7:0] tick_cnt;
    logic tick;
    logic [15:0] acc;
    rag_gain_t stage;
    logic [8:0] dgc_out;
    logic [7:0] rdata;
    logic rvalid;
  } rag_state_t;

endpackage : rag_pkg

/* File: hdl/rag_ctrl.sv */
`timescale 1ns/10ps
module rag_ctrl
  import rag_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire rag_cmd_t i_reg,
  input wire logic i_sleep,
  input wire logic i_adc_done,
  input wire logic [9:0] i_adc_data,
  input wire logic [3:0] i_cond,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_adc_start,
  output logic [2:0] o_mux_sel,
  output logic o_ref_enable,
  output logic [1:0] o_gain_stage,
  output logic [8:0] o_dgc
);

  rag_state_t st;
  rag_state_t next_st;

  // Condition code 0 is never, 1 is always, 2 to 5 pick one of the condition inputs.
  function automatic logic cond_met(input logic [2:0] cfg, input logic [3:0] cond);
    case (cfg)
      3'h0: cond_met = 1'b0;
      3'h1: cond_met = 1'b1;
      3'h2: cond_met = cond[0];
      3'h3: cond_met = cond[1];
      3'h4: cond_met = cond[2];
      3'h5: cond_met = cond[3];
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

  function automatic logic signed [10:0] ext11(input logic [7:0] v);
    ext11 = $signed({3'h0, v});
  endfunction : ext11

  logic conv_ok;
  logic run;
  assign conv_ok = i_adc_done && !st.su_busy;
  assign run = cond_met(st.start_cfg, i_cond) && !cond_met(st.frz_cfg, i_cond);

  always_comb begin : comb_p
    logic signed [16:0] err;
    logic signed [16:0] delta;
    logic signed [16:0] nacc;
    logic [4:0] sh;
    logic signed [10:0] lvl;
    logic signed [10:0] lo_pt;
    logic signed [10:0] hi_pt;
    logic signed [10:0] hys;
    err = $signed({1'b0, st.res[9:2], 8'h00}) - $signed({1'b0, st.acc});
    sh = (err > 17'sd0) ? {1'b0, st.att} : {1'b0, st.att} + {1'b0, st.dec};
    delta = err >>> sh;
    nacc = $signed({1'b0, st.acc}) + delta;
    lvl = ext11(st.acc[15:8]);
    lo_pt = ext11(st.offs) + ext11(st.th_lo);
    hi_pt = ext11(st.offs) + ext11(st.th_hi);
    hys = ext11(st.hys);
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.tick = 1'b0;
    if (st.tick_cnt == ADC_DIV - 8'h01) begin
      next_st.tick_cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 8'h01;
    end
    if (st.su_busy) begin
      if (st.su_cnt == 12'h000) begin
        next_st.su_busy = 1'b0;
      end else begin
        next_st.su_cnt = st.su_cnt - 12'h001;
      end
    end
    // Conversions during reference start-up are discarded.
    if (conv_ok) begin
      next_st.res = i_adc_data;
      next_st.eoc = 1'b1;
      if (st.sel == SEL_RSSI && run) begin
        next_st.acc = nacc[15:0];
      end
    end
    case (st.stage)
      GS_MAX: begin
        if (lvl >= lo_pt) begin
          next_st.stage = GS_MID;
        end
      end
      GS_MID: begin
        if (lvl >= hi_pt) begin
          next_st.stage = GS_MIN;
        end else if (lvl < lo_pt - hys) begin
          next_st.stage = GS_MAX;
        end
      end
      GS_MIN: begin
        if (lvl < hi_pt - hys) begin
          next_st.stage = GS_MID;
        end
      end
      default: next_st.stage = GS_MAX;
    endcase
    case (st.stage)
      GS_MID: next_st.dgc_out = {1'b0, st.digital_gain_correction};
      GS_MIN: next_st.dgc_out = {st.digital_gain_correction, 1'b0};
      default: next_st.dgc_out = 9'h000;
    endcase
    if (i_reg.wr) begin
      case (i_reg.addr)
        ADDR_SEL: begin
          next_st.sel = i_reg.wdata[2:0];
          if (st.sel == SEL_RSSI && i_reg.wdata[2:0] != SEL_RSSI && i_sleep) begin
            next_st.ref_en = 1'b1;
            next_st.su_busy = 1'b1;
            next_st.su_cnt = STARTUP_CYC - 12'h001;
          end
          if (i_reg.wdata[2:0] == SEL_RSSI) begin
            next_st.ref_en = 1'b0;
            next_st.su_busy = 1'b0;
          end
        end
        ADDR_ATTACK: next_st.att = i_reg.wdata[3:0];
        ADDR_DECAY: next_st.dec = i_reg.wdata[3:0];
        ADDR_TH_LOW: next_st.th_lo = i_reg.wdata;
        ADDR_TH_HIGH: next_st.th_hi = i_reg.wdata;
        ADDR_TH_HYS: next_st.hys = i_reg.wdata;
        ADDR_TH_OFFS: next_st.offs = i_reg.wdata;
        ADDR_DGC: next_st.digital_gain_correction = i_reg.wdata;
        ADDR_START: next_st.start_cfg = i_reg.wdata[2:0];
        ADDR_FREEZE: next_st.frz_cfg = i_reg.wdata[2:0];
        default: ;
      endcase
    end
    if (i_reg.rd) begin
      next_st.rvalid = 1'b1;
      case (i_reg.addr)
        ADDR_SEL: next_st.rdata = {5'h00, st.sel};
        ADDR_RES_HIGH: next_st.rdata = st.res[9:2];
        ADDR_RES_LOW: next_st.rdata = {6'h00, st.res[1:0]};
        ADDR_STATUS: next_st.rdata = {6'h00, st.su_busy, st.eoc};
        ADDR_ATTACK: next_st.rdata = {4'h0, st.att};
        ADDR_DECAY: next_st.rdata = {4'h0, st.dec};
        ADDR_TH_LOW: next_st.rdata = st.th_lo;
        ADDR_TH_HIGH: next_st.rdata = st.th_hi;
        ADDR_TH_HYS: next_st.rdata = st.hys;
        ADDR_TH_OFFS: next_st.rdata = st.offs;
        ADDR_DGC: next_st.rdata = st.digital_gain_correction;
        ADDR_START: next_st.rdata = {5'h00, st.start_cfg};
        ADDR_FREEZE: next_st.rdata = {5'h00, st.frz_cfg};
        ADDR_LEVEL: next_st.rdata = st.acc[15:8];
        default: next_st.rdata = 8'h00;
      endcase
      // A conversion landing in the same cycle keeps the flag set.
      if (i_reg.addr == ADDR_RES_HIGH && !conv_ok) begin
        next_st.eoc = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.sel <= SEL_RSSI;
      st.att <= ATTACK_RST;
      st.dec <= DECAY_RST;
      st.th_lo <= TH_LOW_RST;
      st.th_hi <= TH_HIGH_RST;
      st.hys <= TH_HYS_RST;
      st.offs <= TH_OFFS_RST;
      st.digital_gain_correction <= DGC_RST;
      st.start_cfg <= COND_RST;
      st.frz_cfg <= COND_RST;
      st.stage <= GS_MAX;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata = st.rdata;
  assign o_reg_rvalid = st.rvalid;
  assign o_adc_start = st.tick;
  assign o_mux_sel = st.sel;
  assign o_ref_enable = st.ref_en;
  assign o_gain_stage = st.stage;
  assign o_dgc = st.dgc_out;

  localparam int ADC_DIV_I = int'(ADC_DIV);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_SLEEP_STARTUP: assert property (
    i_reg.wr && i_reg.addr == ADDR_SEL && st.sel == SEL_RSSI && i_reg.wdata[2:0] != SEL_RSSI
    && i_sleep |=> o_ref_enable && st.su_busy && st.su_cnt == STARTUP_CYC - 12'h001)
    else $error("startup not entered on selector change in sleep");
  AST_STARTUP_END: assert property (
    st.su_busy && st.su_cnt == 12'h000 && !i_reg.wr |=> !st.su_busy)
    else $error("startup interval did not end on time");
  AST_REF_HOLD: assert property (
    o_ref_enable && !(i_reg.wr && i_reg.addr == ADDR_SEL && i_reg.wdata[2:0] == SEL_RSSI)
    |=> o_ref_enable)
    else $error("references dropped without selector return");
  AST_REF_OFF: assert property (
    i_reg.wr && i_reg.addr == ADDR_SEL && i_reg.wdata[2:0] == SEL_RSSI |=> !o_ref_enable)
    else $error("references kept after selector return");
  AST_EOC_SET: assert property (
    conv_ok |=> st.eoc && st.res == $past(i_adc_data))
    else $error("conversion not flagged or stored");
  AST_RES_HOLD: assert property (
    !conv_ok |=> $stable(st.res))
    else $error("result changed without a completed conversion");
  AST_RES_READ: assert property (
    i_reg.rd && i_reg.addr == ADDR_RES_HIGH |=> o_reg_rvalid && o_reg_rdata == $past(st.res[9:2]))
    else $error("high result read wrong");
  AST_TICK_RATE: assert property (
    o_adc_start |=> !o_adc_start ##(ADC_DIV_I - 2) !o_adc_start ##1 o_adc_start)
    else $error("sample tick period wrong");
  AST_DECAY_DIR: assert property (
    conv_ok && st.sel == SEL_RSSI && run && {st.res[9:2], 8'h00} < st.acc
    |=> st.acc <= $past(st.acc))
    else $error("integrator rose on a falling input");
  AST_STAGE_STEP: assert property (
    st.stage != $past(st.stage) |-> (st.stage == GS_MID || $past(st.stage) == GS_MID))
    else $error("gain stage skipped a step");

endmodule : rag_ctrl

/* File: bench/rag_adc_model.sv */
`timescale 1ns/10ps
module rag_adc_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [9:0] i_val,
  output logic o_done,
  output logic [9:0] o_data
);
  int cnt;
  logic [9:0] last;
  // Converts for 20 clocks after each start tick; data is only good with done.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_data <= 10'h000;
      last <= 10'h000;
    end else begin
      o_done <= 1'b0;
      o_data <= ~last;
      if (i_start) begin
        cnt <= 20;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_done <= 1'b1;
        o_data <= i_val;
        last <= i_val;
      end
    end
  end
endmodule : rag_adc_model

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import rag_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sleep = 1'b0;
  logic [9:0] adc_val = 10'h2c5;
  logic [3:0] cond = 4'h0;
  rag_cmd_t i_reg = '0;
  logic adc_done, o_reg_rvalid, o_adc_start, o_ref_enable;
  logic [9:0] adc_data;
  logic [7:0] o_reg_rdata, q;
  logic [2:0] o_mux_sel;
  logic [1:0] o_gain_stage;
  logic [8:0] o_dgc;
  int fails = 0;
  int n_tests = 0;
  localparam logic [7:0] RST_ADDR [11] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0a, 8'h0b, 8'h0c, 8'h20};
  localparam logic [7:0] RST_VAL [11] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h04, 8'h15, 8'h40,
    8'h0f, 8'h00, 8'h00, 8'h00};
  always #12.5 i_sys_clk = ~i_sys_clk;
  rag_ctrl uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg(i_reg), .i_sleep(i_sleep),
    .i_adc_done(adc_done), .i_adc_data(adc_data), .i_cond(cond), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_adc_start(o_adc_start), .o_mux_sel(o_mux_sel),
    .o_ref_enable(o_ref_enable), .o_gain_stage(o_gain_stage), .o_dgc(o_dgc));
  rag_adc_model adc (.i_clk(i_sys_clk), .i_rst(i_rst), .i_start(o_adc_start),
    .i_val(adc_val), .o_done(adc_done), .o_data(adc_data));
  task automatic chk(input logic [9:0] exp, input logic [9:0] got, input string nm);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w && (a == ADDR_RES_HIGH || a == ADDR_RES_LOW)) cyc(148);
    @(negedge i_sys_clk) i_reg = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_sys_clk) i_reg = '0;
    if (!w) begin
      chk(10'h001, {9'h000, o_reg_rvalid}, "rvalid");
      q = o_reg_rdata;
    end
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    acc(1'b0, a, 8'h00);
    chk({2'b00, exp}, {2'b00, q}, nm);
  endtask : rd
  task automatic wconv;
    int i;
    i = 0;
    while (adc_done !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
    chk(10'h001, {9'h000, adc_done}, "adc_done");
    cyc(2);
  endtask : wconv
  task automatic t_reset;
    for (int i = 0; i < 11; i++) rd(RST_ADDR[i], RST_VAL[i], "reset value");
    chk(10'h000, {7'h00, o_mux_sel}, "mux after reset");
  endtask : t_reset
  task automatic t_select;
    for (int c = 1; c < 3; c++) begin
      acc(1'b1, ADDR_SEL, 8'(c));
      chk(10'(c), {7'h00, o_mux_sel}, "mux select");
      chk(10'h000, {9'h000, o_ref_enable}, "refs when awake");
    end
    acc(1'b1, ADDR_SEL, 8'h00);
  endtask : t_select
  task automatic t_result;
    int sum;
    sum = 0;
    wconv();
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(10'h001, {9'h000, q[STATUS_EOC_BIT]}, "eoc set");
    // A write to the read-only result must leave the stored conversion alone.
    acc(1'b1, ADDR_RES_HIGH, 8'haa);
    rd(ADDR_RES_HIGH, adc_val[9:2], "result high");
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(10'h000, {9'h000, q[STATUS_EOC_BIT]}, "eoc cleared");
    rd(ADDR_RES_LOW, {6'h00, adc_val[1:0]}, "result low");
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, ADDR_RES_HIGH, 8'h00);
      sum += int'(q);
    end
    chk({2'b00, adc_val[9:2]}, 10'(sum / 4), "averaged result high");
  endtask : t_result
  task automatic t_startup;
    logic [9:0] old;
    old = adc_val;
    i_sleep = 1'b1;
    acc(1'b1, ADDR_SEL, 8'h01);
    chk(10'h001, {9'h000, o_ref_enable}, "refs on");
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(10'h001, {9'h000, q[STATUS_BUSY_BIT]}, "busy");
    adc_val = 10'h13a;
    cyc(3700);
    rd(ADDR_RES_HIGH, old[9:2], "held during startup");
    cyc(400);
    wconv();
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(10'h000, {9'h000, q[STATUS_BUSY_BIT]}, "busy done");
    rd(ADDR_RES_HIGH, adc_val[9:2], "after startup");
    chk(10'h001, {9'h000, o_ref_enable}, "refs stay");
    acc(1'b1, ADDR_SEL, 8'h00);
    chk(10'h000, {9'h000, o_ref_enable}, "refs off");
    i_sleep = 1'b0;
  endtask : t_startup
  task automatic t_gain;
    int n;
    logic [7:0] lvl;
    n = 0;
    while (o_adc_start !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (o_adc_start !== 1'b1 && n < 300);
    chk(10'd146, 10'(n), "sample period");
    acc(1'b1, ADDR_ATTACK, 8'h04);
    acc(1'b1, ADDR_DECAY, 8'h04);
    acc(1'b1, ADDR_TH_HYS, 8'h15);
    acc(1'b1, ADDR_DGC, 8'h0f);
    acc(1'b1, ADDR_TH_LOW, 8'h05);
    acc(1'b1, ADDR_TH_HIGH, 8'h01);
    acc(1'b1, ADDR_START, 8'h01);
    // The model's level stands for the signal strength before offset compensation; the offset is added to the thresholds.
    adc_val = 10'h3ff;
    n = 0;
    while (o_gain_stage !== 2'h2 && n < 9000) begin
      cyc(1);
      n++;
    end
    cyc(3);
    chk(10'h002, {8'h00, o_gain_stage}, "gain stage");
    chk(10'h01e, {1'b0, o_dgc}, "gain correction");
    cond = 4'h1;
    acc(1'b1, ADDR_FREEZE, 8'h02);
    acc(1'b0, ADDR_LEVEL, 8'h00);
    lvl = q;
    adc_val = 10'h000;
    cyc(300);
    rd(ADDR_LEVEL, lvl, "level frozen");
    cond = 4'h0;
    n = 0;
    while (o_gain_stage !== 2'h0 && n < 30000) begin
      cyc(1);
      n++;
    end
    cyc(3);
    chk(10'h000, {8'h00, o_gain_stage}, "gain back to max");
    chk(10'h000, {1'b0, o_dgc}, "gain correction off");
    acc(1'b0, ADDR_LEVEL, 8'h00);
    chk(10'h001, {9'h000, q < 8'h30}, "decayed level below switch-back");
  endtask : t_gain
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    cyc(3);
    i_rst = 1'b0;
    t_reset();
    t_select();
    t_result();
    t_startup();
    t_gain();
    summarize();
  end
  initial begin
    #2_000_000;
    fails++;
    summarize();
  end
endmodule : testbench
